// ===== hdl/smsd_map.svh
// Constants for the synchronous modem serial datapath.
// Assumes inclusion by bare name from the package and the datapath module.
`ifndef SMSD_MAP_SVH
`define SMSD_MAP_SVH
// =====================================================
// Widths and status-test bit positions
`define SMSD_CHAR_W 8
`define SMSD_BUS_W 16
`define SMSD_TEST_W 10
`define SMSD_TB_DSR 0
`define SMSD_TB_CTS 1
`define SMSD_TB_DCD 2
`define SMSD_TB_MOD 3
`define SMSD_TB_RING 4
`define SMSD_TB_DMODE 5
`define SMSD_TB_LINEFREE 6
// =====================================================
// Reset values and full-character shift count
`define SMSD_PARITY_EVEN 8'h00
`define SMSD_OUTBUF_RST 16'h0000
`define SMSD_SHIFT_CNT 4'h8
`endif

// ===== hdl/smsd_pkg.sv
// Types for the synchronous modem serial datapath.
// Assumes smsd_map.svh is on the include path.
`include "smsd_map.svh"
package smsd_pkg;
	// =====================================================
	// Block transfer handshake states
	typedef enum logic [2:0]
	{
		SMSD_BT_IDLE,
		SMSD_BT_WAIT_DISC,
		SMSD_BT_WAIT_FUNC,
		SMSD_BT_CONN
	} smsd_bt_state_t;
	typedef logic [`SMSD_CHAR_W-1:0] smsd_char_t;
endpackage : smsd_pkg

// ===== hdl/smsd_datapath.sv
// Datapath of a synchronous modem interface: status test, receive
// converter, input buffer, output buffer, transmit converter, block
// parity and block transfer handshake.
// Assumes one 125 MHz clock; modem clocks arrive as pins and are
// turned into one-cycle enables after synchronising.
// How it works
// - Status test samples modem lines via code
// - Bit0 plus ready set gives skip reply
// - Test condition needs three strobes together
// - Test and qualifier clear receive ready
// - Carrier-gated data shifts per receive clock
// - Load trigger copies converter into buffer
// - Gate strobe drives buffer onto bus
// - Buffer strobe loads sixteen bus bits
// - Master clear empties output buffer
// - Master clear resets transmit converter
// - Parallel load sets stage for zero bits
// - Each step pulse shifts one bit out
// - Eight-bit column parity over received block
// - Sync mode entry sets even parity
// - Ones toggle parity bits, XOR
// - Parity load sends check character
// - Function bit0 raises initialize
// - Function bit1 sets direction signal
// - Accept after disconnect drops, then connect
// - Connected device requests each word
// - Answer each word strobe per direction
`timescale 1ns/10ps
`include "smsd_map.svh"
module smsd_datapath
	import smsd_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic master_clear_in,
	// Status test
	input wire logic second_word_present_in,
	input wire logic test_op_line_in,
	input wire logic unit_selected_in,
	input wire logic [`SMSD_TEST_W-1:0] test_code_in,
	input wire logic receive_qualifier_in,
	input wire logic [6:0] modem_status_in,
	output logic skip_reply_out,
	output logic receive_check_clear_out,
	// Receive side
	input wire logic rx_data_in,
	input wire logic rx_clock_in,
	input wire logic carrier_detect_in,
	input wire logic input_buffer_load_in,
	input wire logic gate_data_out_in,
	input wire logic bus_ready_in,
	output logic [`SMSD_CHAR_W-1:0] bus_data_out,
	output logic bus_data_valid_out,
	output logic input_buffer_full_out,
	// Transmit side
	input wire logic buffer_strobe_in,
	input wire logic [`SMSD_BUS_W-1:0] bus_data_in,
	input wire logic transmit_parallel_load_in,
	input wire logic parity_char_load_in,
	input wire logic main_clock_in,
	input wire logic sync_mode_in,
	output logic tx_data_out,
	output logic [`SMSD_BUS_W-1:0] out_buffer_out,
	output logic [`SMSD_CHAR_W-1:0] block_parity_out,
	// Block transfer controller
	input wire logic [1:0] function_bits_in,
	input wire logic unit_disconnect_in,
	input wire logic bt_data_here_in,
	input wire logic end_of_block_in,
	output logic initialize_out,
	output logic io_direction_out,
	output logic unit_data_accepted_out,
	output logic unit_connected_out,
	output logic data_transfer_request_out,
	output logic unit_data_here_out
);
	// =====================================================
	// Pin synchronisers
	logic [3:0] pin_s1_q; // First stage, read only by second
	logic [3:0] pin_s2_q;
	logic [1:0] clk_hist_q; // Edge history of rx and main clocks
	always_ff @(posedge clk_in)
	begin
		pin_s1_q <= {main_clock_in, rx_clock_in, carrier_detect_in, rx_data_in};
		pin_s2_q <= pin_s1_q;
		clk_hist_q <= pin_s2_q[3:2];
	end
	wire rx_data_s = pin_s2_q[0];
	wire carrier_s = pin_s2_q[1];
	wire rx_tick = pin_s2_q[2] & ~clk_hist_q[0];
	wire step_tick = pin_s2_q[3] & ~clk_hist_q[1];

	// =====================================================
	// Status test
	wire test_cond = second_word_present_in & test_op_line_in & unit_selected_in;
	wire [6:0] status_hit = test_code_in[6:0] & modem_status_in;
	wire skip_d = test_cond & (|status_hit);
	wire rcc_d = test_cond & receive_qualifier_in;
	// Registered so outputs come from flops
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			skip_reply_out <= 1'b0;
			receive_check_clear_out <= 1'b0;
		end
		else
		begin
			skip_reply_out <= skip_d;
			receive_check_clear_out <= rcc_d;
		end
	end

	// =====================================================
	// Receive converter and input buffer
	smsd_char_t rx_shift_q; // Serial to parallel stages
	logic [3:0] rx_count_q; // Shifts since last load
	smsd_char_t in_buf_q; // Held character
	logic full_q;
	logic [3:0] rx_count_d;
	assign rx_count_d = (rx_count_q == `SMSD_SHIFT_CNT) ? rx_count_q : rx_count_q + 4'h1;
	wire rx_bit = rx_data_s & carrier_s; // Carrier gates the data
	// Shift on each rising receive clock edge
	always_ff @(posedge clk_in)
	begin
		if (rst_in | master_clear_in)
		begin
			rx_shift_q <= 8'h00;
			rx_count_q <= 4'h0;
		end
		else if (input_buffer_load_in)
			rx_count_q <= 4'h0;
		else if (rx_tick)
		begin
			rx_shift_q <= {rx_shift_q[6:0], rx_bit};
			rx_count_q <= rx_count_d;
		end
	end
	// Buffer load; ready cleared by test clear or gating
	always_ff @(posedge clk_in)
	begin
		if (rst_in | master_clear_in)
		begin
			in_buf_q <= 8'h00;
			full_q <= 1'b0;
		end
		else if (input_buffer_load_in)
		begin
			in_buf_q <= rx_shift_q;
			full_q <= 1'b1;
		end
		else if (gate_data_out_in | rcc_d)
			full_q <= 1'b0;
	end
	assign input_buffer_full_out = full_q;

	// =====================================================
	// Two-entry output buffer toward the bus
	// Keeps up to two gated words while the bus stalls; a gate with both entries full is dropped
	smsd_char_t fifo_q [0:1];
	logic [1:0] fifo_cnt_q;
	logic fifo_rd_q;
	wire fifo_ready = (fifo_cnt_q != 2'h2);
	wire push = gate_data_out_in & fifo_ready;
	wire pop = bus_data_valid_out & bus_ready_in;
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			fifo_cnt_q <= 2'h0;
			fifo_rd_q <= 1'b0;
		end
		else
		begin
			if (push)
				fifo_q[fifo_rd_q ^ fifo_cnt_q[0]] <= in_buf_q;
			if (pop)
				fifo_rd_q <= ~fifo_rd_q;
			fifo_cnt_q <= fifo_cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end
	// Bus outputs from flops: head word and valid
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			bus_data_out <= 8'h00;
			bus_data_valid_out <= 1'b0;
		end
		else
		begin
			bus_data_valid_out <= (fifo_cnt_q + {1'b0, push} - {1'b0, pop}) != 2'h0;
			bus_data_out <= (fifo_cnt_q == 2'h0 || (pop && fifo_cnt_q == 2'h1)) ? in_buf_q
				: fifo_q[pop ? ~fifo_rd_q : fifo_rd_q];
		end
	end

	// =====================================================
	// Output buffer and transmit converter
	logic [`SMSD_BUS_W-1:0] out_buf_q;
	smsd_char_t tx_shift_q;
	smsd_char_t parity_q;
	logic sync_q;
	// Output buffer load
	always_ff @(posedge clk_in)
	begin
		if (rst_in | master_clear_in)
			out_buf_q <= `SMSD_OUTBUF_RST;
		else if (buffer_strobe_in)
			out_buf_q <= bus_data_in;
	end
	assign out_buffer_out = out_buf_q;
	// Transmit converter; loads take priority over shifting
	always_ff @(posedge clk_in)
	begin
		if (rst_in | master_clear_in)
			tx_shift_q <= 8'h00;
		else if (transmit_parallel_load_in)
			tx_shift_q <= ~out_buf_q[7:0];
		else if (parity_char_load_in)
			tx_shift_q <= ~parity_q;
		else if (step_tick)
			tx_shift_q <= {tx_shift_q[6:0], 1'b0};
	end
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			tx_data_out <= 1'b0;
		else
			tx_data_out <= tx_shift_q[7];
	end

	// =====================================================
	// Block parity
	always_ff @(posedge clk_in)
	begin
		if (rst_in | master_clear_in)
		begin
			parity_q <= `SMSD_PARITY_EVEN;
			sync_q <= 1'b0;
		end
		else
		begin
			sync_q <= sync_mode_in;
			if (sync_mode_in & ~sync_q)
				parity_q <= `SMSD_PARITY_EVEN;
			else if (input_buffer_load_in)
				parity_q <= parity_q ^ rx_shift_q;
		end
	end
	assign block_parity_out = parity_q;

	// =====================================================
	// Block transfer controller handshake
	smsd_bt_state_t bt_q;
	wire func_any = |function_bits_in;
	always_ff @(posedge clk_in)
	begin
		if (rst_in | master_clear_in)
		begin
			bt_q <= SMSD_BT_IDLE;
			initialize_out <= 1'b0;
			io_direction_out <= 1'b0;
			unit_data_accepted_out <= 1'b0;
			unit_connected_out <= 1'b0;
			data_transfer_request_out <= 1'b0;
			unit_data_here_out <= 1'b0;
		end
		else
		begin
			unit_data_accepted_out <= 1'b0;
			unit_data_here_out <= 1'b0;
			unique case (bt_q)
				SMSD_BT_IDLE:
				begin
					if (function_bits_in[0])
					begin
						initialize_out <= 1'b1;
						io_direction_out <= function_bits_in[1];
						bt_q <= SMSD_BT_WAIT_DISC;
					end
				end
				SMSD_BT_WAIT_DISC:
				begin
					if (!unit_disconnect_in)
					begin
						unit_data_accepted_out <= 1'b1;
						bt_q <= SMSD_BT_WAIT_FUNC;
					end
				end
				SMSD_BT_WAIT_FUNC:
				begin
					if (!func_any)
					begin
						unit_connected_out <= 1'b1;
						data_transfer_request_out <= 1'b1;
						bt_q <= SMSD_BT_CONN;
					end
				end
				SMSD_BT_CONN:
				begin
					if (end_of_block_in & unit_disconnect_in)
					begin
						initialize_out <= 1'b0;
						unit_connected_out <= 1'b0;
						data_transfer_request_out <= 1'b0;
						bt_q <= SMSD_BT_IDLE;
					end
					else if (io_direction_out)
						unit_data_accepted_out <= gate_data_out_in;
					else
						unit_data_here_out <= bt_data_here_in;
				end
			endcase
		end
	end

	// =====================================================
	// Assertions
	a_skip_cause: assert property (@(posedge clk_in) disable iff (rst_in)
		(test_cond & test_code_in[0] & modem_status_in[0]) |=> skip_reply_out)
		else $error("skip reply missing");
	a_skip_none: assert property (@(posedge clk_in) disable iff (rst_in)
		!test_cond |=> !skip_reply_out)
		else $error("skip without test condition");
	a_skip_other: assert property (@(posedge clk_in) disable iff (rst_in)
		(test_cond & ~|(test_code_in[6:0] & modem_status_in)) |=> !skip_reply_out)
		else $error("skip with no condition true");
	a_rcc_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
		(test_cond & receive_qualifier_in & !input_buffer_load_in & !master_clear_in)
		|=> receive_check_clear_out && !input_buffer_full_out)
		else $error("receive clear missing");
	a_ibuf_load: assert property (@(posedge clk_in) disable iff (rst_in)
		(input_buffer_load_in & !master_clear_in) |=> in_buf_q == $past(rx_shift_q))
		else $error("input buffer load wrong");
	a_obuf_load: assert property (@(posedge clk_in) disable iff (rst_in)
		(buffer_strobe_in & !master_clear_in) |=> out_buffer_out == $past(bus_data_in))
		else $error("output buffer load wrong");
	a_obuf_clear: assert property (@(posedge clk_in) disable iff (rst_in)
		master_clear_in |=> out_buffer_out == 16'h0000)
		else $error("master clear left data");
	a_tx_inv_load: assert property (@(posedge clk_in) disable iff (rst_in)
		(transmit_parallel_load_in & !master_clear_in) |=> tx_shift_q == ~$past(out_buf_q[7:0]))
		else $error("inverted load wrong");
	a_parity_xor: assert property (@(posedge clk_in) disable iff (rst_in)
		(input_buffer_load_in & !master_clear_in & !(sync_mode_in & ~sync_q))
		|=> parity_q == ($past(parity_q) ^ $past(rx_shift_q)))
		else $error("parity accumulate wrong");
	a_bt_connect: assert property (@(posedge clk_in) disable iff (rst_in)
		(bt_q == SMSD_BT_WAIT_FUNC & !func_any & !master_clear_in)
		|=> unit_connected_out && data_transfer_request_out)
		else $error("connect missing");
	c_skip: cover property (@(posedge clk_in) skip_reply_out);
	c_bus_full: cover property (@(posedge clk_in) fifo_cnt_q == 2'h2);
	c_connect: cover property (@(posedge clk_in) unit_connected_out);
	c_parity_send: cover property (@(posedge clk_in) parity_char_load_in);
	// A full character of eight shifts reaches the buffer
	c_full_char: cover property (@(posedge clk_in) input_buffer_load_in && rx_count_q == `SMSD_SHIFT_CNT);
endmodule : smsd_datapath

// ===== tb/smsd_modem_model.sv
// Modem model: serial receive frames and transmit clock pulses.
// Assumes the bench raises one request at a time and waits on busy.
`timescale 1ns/10ps
module smsd_modem_model (
	// Clock and requests
	input wire logic clk_in,
	input wire logic send_in,
	input wire logic [7:0] byte_in,
	input wire logic step_in,
	// Modem lines
	output logic rx_clock_out = 1'b0,
	output logic rx_data_out = 1'b0,
	output logic carrier_out = 1'b0,
	output logic main_clock_out = 1'b0,
	output logic busy_out = 1'b0
);
	// Latched frame byte
	logic [7:0] frame;
	// =====================================================
	// Receive clock stands still outside frames; main clock pulses on step requests
	always @(posedge clk_in)
		if (send_in)
		begin
			frame = byte_in;
			busy_out <= 1'b1;
			carrier_out <= 1'b1;
			for (int i = 7; i >= 0; i--)
			begin
				rx_data_out <= frame[i];
				repeat (6) @(posedge clk_in);
				rx_clock_out <= 1'b1;
				repeat (6) @(posedge clk_in);
				rx_clock_out <= 1'b0;
			end
			// Released line shows the inverse, never a stale bit
			rx_data_out <= ~frame[0];
			carrier_out <= 1'b0;
			busy_out <= 1'b0;
		end
		else if (step_in)
		begin
			busy_out <= 1'b1;
			main_clock_out <= 1'b1;
			repeat (6) @(posedge clk_in);
			main_clock_out <= 1'b0;
			repeat (6) @(posedge clk_in);
			busy_out <= 1'b0;
		end
endmodule : smsd_modem_model

// ===== tb/sync_modem_serial_datapath_test.sv
// Self-checking bench for the modem serial datapath.
// Assumes the design package and the modem model are compiled first.
`timescale 1ns/10ps
module sync_modem_serial_datapath_test;
	import smsd_pkg::*;
	// =====================================================
	// Design inputs, all valued at time zero
	logic clk_in = 1'b0, rst_in = 1'b1, master_clear_in = 1'b0, second_word_present_in = 1'b0;
	logic test_op_line_in = 1'b0, unit_selected_in = 1'b0, receive_qualifier_in = 1'b0;
	logic input_buffer_load_in = 1'b0, gate_data_out_in = 1'b0, bus_ready_in = 1'b0, buffer_strobe_in = 1'b0;
	logic transmit_parallel_load_in = 1'b0, parity_char_load_in = 1'b0, sync_mode_in = 1'b0;
	logic unit_disconnect_in = 1'b0, bt_data_here_in = 1'b0, end_of_block_in = 1'b0, send = 1'b0, step = 1'b0;
	logic [9:0] test_code_in = 10'h000;
	logic [6:0] modem_status_in = 7'h00;
	logic [15:0] bus_data_in = 16'h0000;
	logic [1:0] function_bits_in = 2'h0;
	logic [7:0] tx_byte = 8'h00;
	// Modem lines and design outputs
	logic rx_data_in, rx_clock_in, carrier_detect_in, main_clock_in, busy, skip_reply_out, tx_data_out;
	logic receive_check_clear_out, bus_data_valid_out, input_buffer_full_out, initialize_out;
	logic io_direction_out, unit_data_accepted_out, unit_connected_out, data_transfer_request_out;
	logic unit_data_here_out;
	logic [7:0] bus_data_out, block_parity_out;
	logic [15:0] out_buffer_out;
	// Reference model state
	int bad_count = 0, checks_done = 0, par = 0, ob, st, n;
	int exp_q[$];
	always #4 clk_in = ~clk_in;
	smsd_datapath uut (.*);
	smsd_modem_model modem (.clk_in, .send_in(send), .byte_in(tx_byte), .step_in(step),
		.rx_clock_out(rx_clock_in), .rx_data_out(rx_data_in), .carrier_out(carrier_detect_in),
		.main_clock_out(main_clock_in), .busy_out(busy));
	// =====================================================
	// Shared tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	// Bounded wait on the modem, plus synchroniser slack
	task modem_wait;
		@(posedge clk_in);
		send <= 1'b0;
		step <= 1'b0;
		n = 0;
		@(posedge clk_in);
		while (busy !== 1'b0)
		begin
			@(posedge clk_in);
			n++;
			if (n > 300)
			begin
				bad_count++;
				test_done;
			end
		end
		repeat (6) @(posedge clk_in);
		#1;
	endtask : modem_wait
	// Serial word goes out msb first, one bit per main clock
	task shift_out(input logic [7:0] exp);
		@(posedge clk_in);
		#1;
		for (int k = 7; k >= 0; k--)
		begin
			chk(tx_data_out, exp[k]);
			@(posedge clk_in);
			step <= 1'b1;
			modem_wait;
		end
	endtask : shift_out
	// =====================================================
	// Main sequence
	initial
	begin
		void'($urandom(32'hD99C));
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk({skip_reply_out, bus_data_valid_out, unit_connected_out, tx_data_out, out_buffer_out[0]}, 16'h0000);
		// Status test, last pass lacks unit select
		for (int i = 0; i < 8; i++)
		begin
			st = $urandom;
			@(posedge clk_in);
			modem_status_in <= st[6:0];
			test_code_in <= 10'h001 << (i % 7);
			unit_selected_in <= (i != 7);
			second_word_present_in <= 1'b1;
			test_op_line_in <= 1'b1;
			receive_qualifier_in <= i[0];
			@(posedge clk_in);
			second_word_present_in <= 1'b0;
			#1;
			chk(skip_reply_out, (i != 7) && st[i % 7]);
			chk(receive_check_clear_out, (i != 7) && i[0]);
		end
		$display("test status done");
		// Output buffer, inverted load, shift out
		ob = $urandom;
		@(posedge clk_in);
		bus_data_in <= ob[15:0];
		buffer_strobe_in <= 1'b1;
		@(posedge clk_in);
		buffer_strobe_in <= 1'b0;
		bus_data_in <= ~ob[15:0];
		transmit_parallel_load_in <= 1'b1;
		@(posedge clk_in);
		transmit_parallel_load_in <= 1'b0;
		#1;
		chk(out_buffer_out, ob[15:0]);
		shift_out(~ob[7:0]);
		// Low byte zero so the converter fills with ones before the clear
		@(posedge clk_in);
		bus_data_in <= 16'hA500;
		buffer_strobe_in <= 1'b1;
		@(posedge clk_in);
		buffer_strobe_in <= 1'b0;
		transmit_parallel_load_in <= 1'b1;
		@(posedge clk_in);
		transmit_parallel_load_in <= 1'b0;
		master_clear_in <= 1'b1;
		@(posedge clk_in);
		#1;
		chk(tx_data_out, 1'b1);
		@(posedge clk_in);
		master_clear_in <= 1'b0;
		#1;
		chk(out_buffer_out, 16'h0000);
		chk(tx_data_out, 1'b0);
		$display("test transmit done");
		// Three characters into a stalled two-word buffer
		for (int j = 0; j < 3; j++)
		begin
			st = $urandom;
			@(posedge clk_in);
			tx_byte <= st[7:0];
			send <= 1'b1;
			modem_wait;
			@(posedge clk_in);
			input_buffer_load_in <= 1'b1;
			@(posedge clk_in);
			input_buffer_load_in <= 1'b0;
			gate_data_out_in <= 1'b1;
			#1;
			chk(input_buffer_full_out, 1'b1);
			@(posedge clk_in);
			gate_data_out_in <= 1'b0;
			par ^= st[7:0];
			if (j < 2)
				exp_q.push_back(st[7:0]);
		end
		#1;
		chk(block_parity_out, par[7:0]);
		// Check the head word while it stands, then accept it for one cycle
		while (exp_q.size() > 0)
		begin
			for (n = 0; bus_data_valid_out !== 1'b1 && n < 20; n++)
			begin
				@(posedge clk_in);
				#1;
			end
			if (n == 20)
			begin
				bad_count++;
				test_done;
			end
			chk(bus_data_out, exp_q.pop_front());
			@(posedge clk_in);
			bus_ready_in <= 1'b1;
			@(posedge clk_in);
			bus_ready_in <= 1'b0;
			#1;
		end
		@(posedge clk_in);
		#1;
		chk(bus_data_valid_out, 1'b0);
		$display("test receive done");
		// Check character, then sync entry
		@(posedge clk_in);
		parity_char_load_in <= 1'b1;
		@(posedge clk_in);
		parity_char_load_in <= 1'b0;
		shift_out(~par[7:0]);
		@(posedge clk_in);
		sync_mode_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		chk(block_parity_out, 16'h0000);
		$display("test parity done");
		// Block transfer handshake, input then output
		for (int d = 0; d < 2; d++)
		begin
			@(posedge clk_in);
			function_bits_in <= {d[0], 1'b1};
			unit_disconnect_in <= 1'b1;
			end_of_block_in <= 1'b0;
			@(posedge clk_in);
			unit_disconnect_in <= 1'b0;
			#1;
			chk({initialize_out, io_direction_out}, {1'b1, d[0]});
			@(posedge clk_in);
			function_bits_in <= 2'h0;
			#1;
			chk(unit_data_accepted_out, 1'b1);
			@(posedge clk_in);
			gate_data_out_in <= d[0];
			bt_data_here_in <= !d[0];
			#1;
			chk({unit_data_accepted_out, unit_connected_out, data_transfer_request_out}, 3'b011);
			@(posedge clk_in);
			gate_data_out_in <= 1'b0;
			bt_data_here_in <= 1'b0;
			end_of_block_in <= 1'b1;
			unit_disconnect_in <= 1'b1;
			#1;
			chk({unit_data_accepted_out, unit_data_here_out}, {d[0], !d[0]});
			@(posedge clk_in);
			#1;
			chk({unit_connected_out, data_transfer_request_out, initialize_out}, 3'b000);
		end
		$display("test handshake done");
		test_done;
	end
	// Hang guard
	initial
	begin
		#400000;
		bad_count++;
		test_done;
	end
endmodule : sync_modem_serial_datapath_test
